// File: hw/fault_sup_pkg.sv
// Constants, register map and carrier types of the converter fault supervisor.
// Assumes a 40 MHz system clock and a 32-bit APB register bus.
package fault_sup_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned PG_DEGLITCH_US = 40;
  localparam int unsigned PG_DEGLITCH_CYC =
    (PG_DEGLITCH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RETRY_PAUSE_US = 128;
  localparam int unsigned RETRY_PAUSE_CYC =
    (RETRY_PAUSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] RETRY_TRIP_CNT = 6'h20;
  localparam logic [2:0] CURRENT_LIMIT_FLAG_TRIP_CNT = 3'h4;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_STATE = 12'h008;

  // Control register, bits 4:0
  typedef struct packed {
    logic standalone_select;
    logic regulation_ignore_during_ramp;
    logic overload_retry_enable;
    logic output_discharge_enable;
    logic switching_enable_bit;
  } ctrl_t;
  localparam int unsigned CTRL_W = 5;
  localparam ctrl_t CTRL_RST = 5'h03;

  // Status register, bits 3:0, clear on read
  typedef struct packed {
    logic thermal_shutdown_flag;
    logic thermal_warning_flag;
    logic current_limit_flag;
    logic overload_retry_flag;
  } status_t;
  localparam int unsigned STATUS_W = 4;
  localparam status_t STATUS_RST = 4'h0;

  // ----------------------------------------------------------------
  // Run states and pin carrier
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    RUN_OFF = 4'h1,
    RUN_SOFT = 4'h2,
    RUN_ON = 4'h4,
    RUN_PAUSE = 4'h8
  } run_t;

  typedef struct packed {
    logic enable_pin;
    logic supply_low_lockout;
    logic supply_high_lockout;
    logic hs_trip;
    logic ls_above;
    logic thermal_warn;
    logic thermal_shut;
    logic window_fault;
    logic voltage_ramp;
    logic cycle_start;
    logic soft_done;
    logic role_secondary;
    logic pg_line;
  } pin_t;

endpackage

// File: hw/converter_fault_supervisor.sv
// Fault, power-good and status logic of a step-down converter.
// Assumes analogue comparator levels on asynchronous pins, an APB master
// on the system clock, and an external pad resolving open-drain enables.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/10ps

// What this block does
// - Discharge output when disabled by pin, bit, thermal or either supply lockout.
// - Discharge stays unavailable until first enable after power-up.
// - Supply low lockout stops switching; discharge only if enabled.
// - Supply high lockout stops switching; restart with fresh soft start when clear.
// - High-side trip forces low side on until low-side threshold clears.
// - Overload retry only when its enable bit is 1; resets off.
// - 32 tripped cycles pause switching 128 us, then soft start, repeating.
// - Each retry sets its flag and holds power-good low until regulating.
// - Status read clears retry flag only once overload has gone.
// - Without retry keep limiting; four tripped cycles set current limit flag.
// - Status read clears current limit flag only after overload ended.
// - Window fault outside 95..105 percent pulls power-good low at once, without deglitch.
// - Rising, releasing edge of power-good delayed 40 us.
// - Ignore window fault during a voltage ramp when the ignore bit is set.
// - Primary power-good forced low in shutdown, disable, lockout, soft start, retry.
// - Secondary holds shared line low until soft start begins; forces DCM until CCM is permitted.
// - Secondary permits CCM only after shared power-good line rises.
// - Both secondary latches return to DCM on every disable except supply high lockout.
// - Thermal warning sets flag; read clears it only below release level.
// - Thermal shutdown stops switching, pulls enable, discharges, sets flag, pg low.
// - Thermal shutdown clear restarts soft start and releases enable and pg.
// - Read clears shutdown flag only below shutdown release level.
module converter_fault_supervisor
  import fault_sup_pkg::*;
#(
  parameter int unsigned PAUSE_CYCLES = RETRY_PAUSE_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Comparators and pins, asynchronous
  input wire logic enable_pin_i,
  input wire logic supply_low_lockout_i,
  input wire logic supply_high_lockout_i,
  input wire logic hs_current_trip_i,
  input wire logic ls_current_above_i,
  input wire logic thermal_warn_i,
  input wire logic thermal_shut_i,
  input wire logic window_fault_i,
  input wire logic voltage_ramp_i,
  input wire logic cycle_start_i,
  input wire logic soft_start_done_i,
  input wire logic role_secondary_i,
  input wire logic power_good_output_i,
  // Power stage control
  output logic switching_o,
  output logic soft_start_run_o,
  output logic hs_off_o,
  output logic ls_force_on_o,
  output logic discharge_o,
  output logic force_dcm_o,
  // Open-drain pins, output value and enable
  output logic power_good_output_o,
  output logic power_good_output_oe_o,
  output logic enable_pin_o,
  output logic enable_pin_oe_o
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    pin_t s1;
    pin_t s2;
    logic cyc_prev;
    logic ssd_prev;
    logic pgl_prev;
    ctrl_t ctrl;
    status_t stat;
    logic enabled_once;
    run_t run;
    logic trip_seen;
    logic last_trip;
    logic [5:0] retry_cnt;
    logic [2:0] current_limit_flag_cnt;
    logic [12:0] pause_cnt;
    logic [10:0] pg_cnt;
    logic pg_ok;
    logic hs_block;
    logic dcm_hold;
    logic ccm_permit;
    logic sw;
    logic ss_run;
    logic hs_off;
    logic ls_on;
    logic dis;
    logic fdcm;
    logic pg_oe;
    logic en_oe;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

  state_t r;
  state_t n;
  pin_t pins;
  pin_t p;

  // ----------------------------------------------------------------
  // Input gathering
  // ----------------------------------------------------------------
  assign pins = '{
    enable_pin: enable_pin_i,
    supply_low_lockout: supply_low_lockout_i,
    supply_high_lockout: supply_high_lockout_i,
    hs_trip: hs_current_trip_i,
    ls_above: ls_current_above_i,
    thermal_warn: thermal_warn_i,
    thermal_shut: thermal_shut_i,
    window_fault: window_fault_i,
    voltage_ramp: voltage_ramp_i,
    cycle_start: cycle_start_i,
    soft_done: soft_start_done_i,
    role_secondary: role_secondary_i,
    pg_line: power_good_output_i
  };
  // Only the second synchroniser stage is ever looked at
  assign p = r.s2;

  // ----------------------------------------------------------------
  // Derived conditions
  // ----------------------------------------------------------------
  logic enabled;
  logic sec_disable;
  logic cyc_edge;
  logic tripped;
  logic retry_fire;
  logic overload_now;
  logic win_fault;
  logic pg_force_low;
  logic good_raw;
  logic acc;
  logic done;
  logic rd_clr;
  logic mapped;

  // Any disabling cause stops the converter
  assign enabled = p.enable_pin & r.ctrl.switching_enable_bit & ~p.thermal_shut
    & ~p.supply_low_lockout & ~p.supply_high_lockout;
  // High lockout is not among the causes that reset the secondary latches
  assign sec_disable = ~p.enable_pin | ~r.ctrl.switching_enable_bit
    | p.thermal_shut | p.supply_low_lockout;
  assign cyc_edge = p.cycle_start & ~r.cyc_prev;
  // A trip seen anywhere in the cycle that just ended
  assign tripped = r.trip_seen;
  assign retry_fire = cyc_edge & tripped & r.ctrl.overload_retry_enable
    & (r.run == RUN_SOFT || r.run == RUN_ON)
    & (r.retry_cnt == RETRY_TRIP_CNT - 6'h01);
  // Overload counts as present while pausing or still tripping
  assign overload_now = r.last_trip | r.trip_seen | (r.run == RUN_PAUSE);
  assign win_fault = p.window_fault
    & ~(r.ctrl.regulation_ignore_during_ramp & p.voltage_ramp);
  assign pg_force_low = p.thermal_shut | ~enabled | p.supply_low_lockout
    | p.supply_high_lockout | (r.run != RUN_ON);
  assign good_raw = ~pg_force_low & ~win_fault;

  // APB decode; the access completes on the second access cycle
  assign acc = psel_i & penable_i;
  assign done = acc & r.pready;
  assign mapped = (paddr_i == ADDR_CTRL) || (paddr_i == ADDR_STATUS)
    || (paddr_i == ADDR_STATE);
  assign rd_clr = done & ~pwrite_i & (paddr_i == ADDR_STATUS);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.s1 = pins;
    n.s2 = r.s1;
    n.cyc_prev = p.cycle_start;
    n.ssd_prev = p.soft_done;
    n.pgl_prev = p.pg_line;

    // First enable arms the discharge path
    if (enabled) begin
      n.enabled_once = 1'b1;
    end

    // Per-cycle trip tracking, trip at the edge belongs to the new cycle
    if (cyc_edge) begin
      n.trip_seen = p.hs_trip;
      n.last_trip = tripped;
      if (tripped) begin
        if (r.retry_cnt != RETRY_TRIP_CNT) begin
          n.retry_cnt = r.retry_cnt + 6'h01;
        end
        if (r.current_limit_flag_cnt != CURRENT_LIMIT_FLAG_TRIP_CNT) begin
          n.current_limit_flag_cnt = r.current_limit_flag_cnt + 3'h1;
        end
      end else begin
        n.retry_cnt = 6'h00;
        n.current_limit_flag_cnt = 3'h0;
      end
    end else if (p.hs_trip) begin
      n.trip_seen = 1'b1;
    end

    // Run sequencing; any disable returns to off, so restarts soft start
    unique case (r.run)
      RUN_OFF: begin
        if (enabled) begin
          n.run = RUN_SOFT;
        end
      end
      RUN_SOFT: begin
        if (p.soft_done & ~r.ssd_prev) begin
          n.run = RUN_ON;
        end
      end
      RUN_ON: begin
        n.run = RUN_ON;
      end
      RUN_PAUSE: begin
        if (r.pause_cnt == 13'(PAUSE_CYCLES - 1)) begin
          n.run = RUN_SOFT;
          n.pause_cnt = 13'h0000;
        end else begin
          n.pause_cnt = r.pause_cnt + 13'h0001;
        end
      end
    endcase
    if (retry_fire) begin
      n.run = RUN_PAUSE;
      n.pause_cnt = 13'h0000;
      n.retry_cnt = 6'h00;
    end
    if (!enabled) begin
      n.run = RUN_OFF;
      n.pause_cnt = 13'h0000;
    end

    // Cycle-by-cycle limit; synchronised comparators add two cycles of lag
    if (!(n.run == RUN_SOFT || n.run == RUN_ON)) begin
      n.hs_block = 1'b0;
    end else if (p.hs_trip) begin
      n.hs_block = 1'b1;
    end else if (!p.ls_above) begin
      n.hs_block = 1'b0;
    end

    // Status flags: set beats a read clear; a live condition blocks the clear
    n.stat.overload_retry_flag = retry_fire
      | (r.stat.overload_retry_flag & ~(rd_clr & ~overload_now));
    n.stat.current_limit_flag =
      (~r.ctrl.overload_retry_enable & (r.current_limit_flag_cnt == CURRENT_LIMIT_FLAG_TRIP_CNT))
      | (r.stat.current_limit_flag & ~(rd_clr & ~overload_now));
    n.stat.thermal_warning_flag = p.thermal_warn
      | (r.stat.thermal_warning_flag & ~(rd_clr & ~p.thermal_warn));
    n.stat.thermal_shutdown_flag = p.thermal_shut
      | (r.stat.thermal_shutdown_flag & ~(rd_clr & ~p.thermal_shut));

    // Power-good deglitch: falls at once, rises after a steady good window
    if (!good_raw) begin
      n.pg_ok = 1'b0;
      n.pg_cnt = 11'h000;
    end else if (!r.pg_ok) begin
      if (r.pg_cnt == 11'(PG_DEGLITCH_CYC - 1)) begin
        n.pg_ok = 1'b1;
      end else begin
        n.pg_cnt = r.pg_cnt + 11'h001;
      end
    end

    // Secondary latches follow start-up and the shared line
    if (sec_disable) begin
      n.dcm_hold = 1'b1;
      n.ccm_permit = 1'b0;
    end else begin
      if (r.run != RUN_OFF) begin
        n.dcm_hold = 1'b0;
      end
      if (p.pg_line & ~r.pgl_prev & ~r.dcm_hold) begin
        n.ccm_permit = 1'b1;
      end
    end

    // Registered outputs
    n.sw = (n.run == RUN_SOFT) || (n.run == RUN_ON);
    n.ss_run = n.sw;
    n.hs_off = ~n.sw | n.hs_block;
    n.ls_on = n.sw & n.hs_block;
    n.dis = r.ctrl.output_discharge_enable & r.enabled_once & ~enabled;
    n.fdcm = p.role_secondary & ~r.ccm_permit;
    // Secondary drives only its hold latch; primary the deglitched status, same cycle as sw
    n.pg_oe = p.role_secondary ? n.dcm_hold : (~n.pg_ok | ~n.sw);
    n.en_oe = p.thermal_shut & ~r.ctrl.standalone_select;

    // APB slave: one wait cycle, data captured before the completing edge
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    if (acc && !r.pready) begin
      n.pready = 1'b1;
      n.pslverr = ~mapped;
      n.prdata = 32'h0000_0000;
      if (!pwrite_i) begin
        if (paddr_i == ADDR_CTRL) begin
          n.prdata[CTRL_W-1:0] = r.ctrl;
        end else if (paddr_i == ADDR_STATUS) begin
          n.prdata[STATUS_W-1:0] = r.stat;
        end else if (paddr_i == ADDR_STATE) begin
          n.prdata[3:0] = r.run;
          n.prdata[4] = r.pg_ok;
          n.prdata[5] = r.dcm_hold;
          n.prdata[6] = r.ccm_permit;
          n.prdata[7] = r.dis;
          n.prdata[8] = r.enabled_once;
        end
      end
    end
    // Writes land on the completing edge only
    if (done && pwrite_i && (paddr_i == ADDR_CTRL)) begin
      n.ctrl = pwdata_i[CTRL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
      r.ctrl <= CTRL_RST;
      r.stat <= STATUS_RST;
      r.run <= RUN_OFF;
      r.dcm_hold <= 1'b1;
      r.hs_off <= 1'b1;
      r.pg_oe <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Output mapping
  // ----------------------------------------------------------------
  assign prdata_o = r.prdata;
  assign pready_o = r.pready;
  assign pslverr_o = r.pslverr;
  assign switching_o = r.sw;
  assign soft_start_run_o = r.ss_run;
  assign hs_off_o = r.hs_off;
  assign ls_force_on_o = r.ls_on;
  assign discharge_o = r.dis;
  assign force_dcm_o = r.fdcm;
  // Open-drain pins only ever pull low
  assign power_good_output_o = r.pgl_prev & 1'b0;
  assign power_good_output_oe_o = r.pg_oe;
  assign enable_pin_o = r.cyc_prev & 1'b0;
  assign enable_pin_oe_o = r.en_oe;

endmodule

// File: verif/power_stage_model.sv
// Power stage and comparator model facing the fault supervisor.
// Assumes the bench supplies the overload request and the clock.
`timescale 1ns/10ps
module power_stage_model (
  // Clock and control
  input wire logic clk_i,
  input wire logic switching_i,
  input wire logic overload_i,
  input wire logic pg_oe_i,
  // Comparator outputs
  output logic cycle_start_o,
  output logic soft_done_o,
  output logic hs_trip_o,
  output logic ls_above_o,
  output logic pg_line_o
);
  logic [2:0] ph_reg = 3'h0;
  logic [5:0] ss_reg = 6'h00;
  logic [1:0] ld_reg = 2'h0;
  // Phase, ramp timer and current decay
  always_ff @(posedge clk_i) begin
    ph_reg <= ph_reg + 3'h1;
    ss_reg <= !switching_i ? 6'h00 : (ss_reg == 6'h3f) ? ss_reg : ss_reg + 6'h01;
    ld_reg <= {ld_reg[0], hs_trip_o};
  end
  // Switching cycle of eight clocks; phase keeps counting when idle, cycle start held low
  assign cycle_start_o = switching_i & ph_reg[2];
  assign soft_done_o = (ss_reg == 6'h3f);
  assign hs_trip_o = overload_i & switching_i & ph_reg[2];
  // Current stays above low threshold after a trip
  assign ls_above_o = hs_trip_o | ld_reg[1];
  // Pull-up on shared power-good line
  assign pg_line_o = !pg_oe_i;
endmodule

// File: verif/converter_fault_supervisor_asserts.sv
// Checker on the supervisor ports.
// Power-good idle and release claims apply to the standalone or primary role only.
`timescale 1ns/10ps
module converter_fault_supervisor_asserts (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic thermal_shut_i,
  input wire logic supply_low_lockout_i,
  input wire logic role_secondary_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic switching_o,
  input wire logic hs_off_o,
  input wire logic ls_force_on_o,
  input wire logic discharge_o,
  input wire logic power_good_output_o,
  input wire logic power_good_output_oe_o,
  input wire logic enable_pin_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // Bus answers after one wait cycle
  a_apb_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("pready late");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("pready long");
  a_err_ready: assert property (pslverr_o |-> pready_o) else $error("pslverr alone");
  // Low side forced only with high side off
  a_ls_hs: assert property (ls_force_on_o |-> hs_off_o) else $error("both switches");
  a_dis_idle: assert property (discharge_o |-> !switching_o)
    else $error("discharge while switching");
  a_pg_idle: assert property (!switching_o && !role_secondary_i |-> power_good_output_oe_o)
    else $error("pg released idle");
  // Release only after a long switching run
  a_pg_rel: assert property ($fell(power_good_output_oe_o) && !role_secondary_i
    |-> $past(switching_o, 300))
    else $error("pg released early");
  a_od_low: assert property (!power_good_output_o && !enable_pin_o)
    else $error("open drain high");
  a_tsd_stop: assert property (thermal_shut_i [*4] |=> !switching_o && power_good_output_oe_o)
    else $error("no shutdown stop");
  a_supply_low_lockout_stop: assert property (supply_low_lockout_i [*4] |=> !switching_o)
    else $error("no lockout stop");
endmodule
bind converter_fault_supervisor converter_fault_supervisor_asserts u_chk (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .thermal_shut_i(thermal_shut_i), .supply_low_lockout_i(supply_low_lockout_i),
  .role_secondary_i(role_secondary_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .switching_o(switching_o),
  .hs_off_o(hs_off_o), .ls_force_on_o(ls_force_on_o), .discharge_o(discharge_o),
  .power_good_output_o(power_good_output_o), .enable_pin_o(enable_pin_o),
  .power_good_output_oe_o(power_good_output_oe_o));

// File: verif/converter_fault_supervisor_tb.sv
// Self-checking bench of the fault supervisor.
// Assumes the power stage model and a pulled-up enable line.
`timescale 1ns/10ps
module converter_fault_supervisor_tb;
  import fault_sup_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, q, prdata;
  logic e, en_drv = 1'b0, sl = 1'b0, sh = 1'b0, tw = 1'b0, ts = 1'b0;
  logic wf = 1'b0, ramp = 1'b0, ovl = 1'b0, cs, sd, hs, ls, pgl;
  logic role = 1'b0, peer = 1'b0;
  logic pready, pslverr, sw, ssr, hso, lso, dis, dcm, pgo, pgoe, eno, enoe;
  int err_total = 0, tests_run = 0, n;
  always #12.5 clk = ~clk;
  converter_fault_supervisor #(.PAUSE_CYCLES(20)) u_converter_fault_supervisor (
    .clk_sys_i(clk), .reset_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .enable_pin_i(en_drv & !enoe), .supply_low_lockout_i(sl), .supply_high_lockout_i(sh),
    .hs_current_trip_i(hs), .ls_current_above_i(ls), .thermal_warn_i(tw),
    .thermal_shut_i(ts), .window_fault_i(wf), .voltage_ramp_i(ramp), .cycle_start_i(cs),
    .soft_start_done_i(sd), .role_secondary_i(role), .power_good_output_i(pgl & !peer),
    .switching_o(sw), .soft_start_run_o(ssr), .hs_off_o(hso), .ls_force_on_o(lso),
    .discharge_o(dis), .force_dcm_o(dcm), .power_good_output_o(pgo),
    .power_good_output_oe_o(pgoe), .enable_pin_o(eno), .enable_pin_oe_o(enoe));
  power_stage_model u_power_stage_model (.clk_i(clk), .switching_i(sw), .overload_i(ovl),
    .pg_oe_i(pgoe), .cycle_start_o(cs), .soft_done_o(sd), .hs_trip_o(hs),
    .ls_above_o(ls), .pg_line_o(pgl));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task print_verdict;
    $display("Counts: %0d checks, %0d mismatches", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Held until pready is seen high at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin err_total++; print_verdict; end
    q = prdata; e = pslverr; psel <= 1'b0; pen <= 1'b0;
    @(posedge clk);
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(q, exp, nm);
  endtask
  // Bounded wait on switching (0) or power-good pull (1)
  task wait_for(input int s, input logic v, input int lim);
    n = 0;
    while (((s == 0) ? sw : pgoe) !== v) begin
      @(posedge clk); n++;
      if (n > lim) begin err_total++; print_verdict; end
    end
  endtask
  task pause6; repeat (6) @(posedge clk); endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    rchk(ADDR_CTRL, 32'h03, "ctrl_rst");
    rchk(ADDR_STATUS, 32'h0, "status_rst");
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, e}, 32'h1, "unmapped_err");
    chk(q, 32'h0, "unmapped_data");
    chk({31'h0, dis}, 32'h0, "dis_before_en");
    chk({30'h0, pgo, eno}, 32'h0, "od_values");
    $display("test reset done");
  endtask
  task t_start;
    en_drv <= 1'b1;
    wait_for(0, 1'b1, 20);
    chk({30'h0, pgoe, ssr}, 32'h3, "pg_soft");
    n = 0;
    while (sd !== 1'b1 && n < 100) begin @(posedge clk); n++; end
    chk({31'h0, sd}, 32'h1, "soft_done");
    wait_for(1, 1'b0, 1700);
    chk({31'h0, n >= PG_DEGLITCH_CYC && n <= PG_DEGLITCH_CYC + 8}, 32'h1, "pg_delay");
    wf <= 1'b1; pause6;
    chk({31'h0, pgoe}, 32'h1, "pg_window");
    apb(1'b1, ADDR_CTRL, 32'h0b);
    wf <= 1'b0; wait_for(1, 1'b0, 1700);
    ramp <= 1'b1; wf <= 1'b1; repeat (10) @(posedge clk);
    chk({31'h0, pgoe}, 32'h0, "pg_ramp_ign");
    ramp <= 1'b0; pause6;
    chk({31'h0, pgoe}, 32'h1, "pg_ramp_end");
    wf <= 1'b0;
    $display("test start done");
  endtask
  task t_current_limit_flag;
    // Two periods at most touch three cycles, so the count stays below four
    ovl <= 1'b1; repeat (16) @(posedge clk); ovl <= 1'b0; repeat (40) @(posedge clk);
    rchk(ADDR_STATUS, 32'h0, "current_limit_flag_short");
    ovl <= 1'b1;
    n = 0;
    while (lso !== 1'b1 && n < 16) begin @(posedge clk); n++; end
    chk({30'h0, lso, hso}, 32'h3, "ls_forced");
    repeat (48) @(posedge clk);
    rchk(ADDR_STATUS, 32'h2, "current_limit_flag_set");
    rchk(ADDR_STATUS, 32'h2, "current_limit_flag_held");
    ovl <= 1'b0; repeat (40) @(posedge clk);
    rchk(ADDR_STATUS, 32'h2, "current_limit_flag_last");
    rchk(ADDR_STATUS, 32'h0, "current_limit_flag_clr");
    $display("test current_limit_flag done");
  endtask
  task t_retry;
    apb(1'b1, ADDR_CTRL, 32'h07);
    ovl <= 1'b1;
    wait_for(0, 1'b0, 400);
    chk({31'h0, pgoe}, 32'h1, "retry_pg");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(q & 32'h1, 32'h1, "retry_flag");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(q & 32'h1, 32'h1, "retry_held");
    wait_for(0, 1'b1, 40);
    wait_for(0, 1'b0, 400);
    ovl <= 1'b0;
    wait_for(0, 1'b1, 40);
    repeat (40) @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(q & 32'h1, 32'h0, "retry_clr");
    apb(1'b1, ADDR_CTRL, 32'h03);
    rchk(ADDR_STATUS, 32'h0, "retry_quiet");
    $display("test retry done");
  endtask
  task t_thermal;
    tw <= 1'b1; pause6;
    rchk(ADDR_STATUS, 32'h4, "warn_set");
    rchk(ADDR_STATUS, 32'h4, "warn_held");
    tw <= 1'b0; pause6;
    rchk(ADDR_STATUS, 32'h4, "warn_last");
    rchk(ADDR_STATUS, 32'h0, "warn_clr");
    ts <= 1'b1; pause6;
    chk({25'h0, sw, ssr, hso, lso, enoe, dis, pgoe}, 32'h17, "tsd_pins");
    rchk(ADDR_STATUS, 32'h8, "tsd_held");
    ts <= 1'b0;
    wait_for(0, 1'b1, 20);
    chk({31'h0, enoe}, 32'h0, "tsd_en_rel");
    rchk(ADDR_STATUS, 32'h8, "tsd_last");
    rchk(ADDR_STATUS, 32'h0, "tsd_clr");
    $display("test thermal done");
  endtask
  task t_lock;
    sh <= 1'b1; pause6;
    chk({30'h0, sw, dis}, 32'h1, "supply_high_lockout_stop");
    sh <= 1'b0;
    wait_for(0, 1'b1, 20);
    apb(1'b1, ADDR_CTRL, 32'h01);
    sl <= 1'b1; pause6;
    chk({29'h0, sw, dis, pgoe}, 32'h1, "supply_low_lockout_nodis");
    sl <= 1'b0;
    wait_for(0, 1'b1, 20);
    en_drv <= 1'b0; pause6;
    chk({31'h0, dis}, 32'h0, "pin_nodis");
    apb(1'b1, ADDR_CTRL, 32'h03); pause6;
    chk({31'h0, dis}, 32'h1, "pin_dis");
    en_drv <= 1'b1; apb(1'b1, ADDR_CTRL, 32'h02); pause6;
    chk({30'h0, sw, dis}, 32'h1, "bit_dis");
    $display("test lockout done");
  endtask
  // Secondary role; a peer holds the shared line low until released
  task t_stack;
    role <= 1'b1; peer <= 1'b1; pause6;
    chk({30'h0, dcm, pgoe}, 32'h3, "sec_hold");
    apb(1'b1, ADDR_CTRL, 32'h03);
    wait_for(0, 1'b1, 20);
    repeat (12) @(posedge clk);
    chk({30'h0, dcm, pgoe}, 32'h2, "sec_released");
    peer <= 1'b0; pause6;
    chk({31'h0, dcm}, 32'h0, "sec_ccm");
    en_drv <= 1'b0; pause6;
    chk({30'h0, dcm, pgoe}, 32'h3, "sec_disable");
    $display("test stack done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_start;
    t_current_limit_flag;
    t_retry;
    t_thermal;
    t_lock;
    t_stack;
    print_verdict;
  end
endmodule
